/* File: rtl/sqflm_consts.vh */
// Constants for the sequencer control and field-loss monitor block.
// Assumes an APB master on pclk and a magnitude input from the datapath.
// How it works
// - Control bit 1 runs the measurement sequencer; resets to 1.
// - Control bit 0 selects single-loop operation when 1; resets to 0.
// - Field-lost flag is set and cleared from magnitude versus threshold and hysteresis.
// - Monitor register low byte holds the eight-bit writable loss threshold.
// - Monitor bits 10..8 hold hysteresis, reset 001; upper bits read zero.
// - Control bits 31..2 are reserved and read as zero.
// - Effective minimum magnitude is threshold value times 64.
// - Hysteresis amount is effective threshold shifted right by hysteresis value.
// - Flag sets below threshold; clears only above threshold plus hysteresis.
`ifndef SQFLM_CONSTS_VH
`define SQFLM_CONSTS_VH
// Printed offsets are register indices; byte address is four times the index.
`define SQFLM_IDX_SEQ_CTRL 12'h00E
`define SQFLM_IDX_THRESH 12'h00F
`define SQFLM_IDX_IRQ_STAT 12'h010
`define SQFLM_IDX_IRQ_MASK 12'h011
`define SQFLM_IDX_FLAG 12'h012
`define SQFLM_CTRL_LOOP_BIT 0
`define SQFLM_CTRL_RUN_BIT 1
`define SQFLM_CTRL_RESET 2'h2
`define SQFLM_THR_LSB 0
`define SQFLM_THR_MSB 7
`define SQFLM_HYS_LSB 8
`define SQFLM_HYS_MSB 10
`define SQFLM_THR_RESET 8'h03
`define SQFLM_HYS_RESET 3'h1
`define SQFLM_MASK_RESET 2'h0
`define SQFLM_THR_SCALE_SHIFT 6
`define SQFLM_IRQ_SET_BIT 0
`define SQFLM_IRQ_CLR_BIT 1
`endif

/* File: rtl/sqflm_top.v */
// Sequencer control register, field-loss monitor and an APB slave for both.
// Assumes a 100 MHz pclk, synchronous inputs and a magnitude sample with a valid strobe.
`include "sqflm_consts.vh"

module sqflm_top #(
	parameter MAG_W = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [13:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [MAG_W-1:0] magnitude,
	input wire magnitude_valid,
	output wire seq_run,
	output wire single_loop_select,
	output wire field_lost_flag,
	output wire irq
);

	// ****************************************
	// Bus decode
	// ****************************************
	wire [11:0] idx = paddr[13:2];
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	reg mapped;

	// Zero-wait slave; unmapped indices answer with an error and zero data.
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	always @* begin
		case (idx)
			`SQFLM_IDX_SEQ_CTRL, `SQFLM_IDX_THRESH, `SQFLM_IDX_IRQ_STAT,
			`SQFLM_IDX_IRQ_MASK, `SQFLM_IDX_FLAG: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	reg [1:0] ctrl_q;
	reg [7:0] thr_q;
	reg [2:0] hys_q;
	reg [1:0] stat_q;
	reg [1:0] mask_q;
	reg lost_q;

	assign seq_run = ctrl_q[`SQFLM_CTRL_RUN_BIT];
	assign single_loop_select = ctrl_q[`SQFLM_CTRL_LOOP_BIT];
	assign field_lost_flag = lost_q;
	assign irq = |(stat_q & mask_q);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `SQFLM_CTRL_RESET;
			thr_q <= `SQFLM_THR_RESET;
			hys_q <= `SQFLM_HYS_RESET;
			mask_q <= `SQFLM_MASK_RESET;
		end else if (wr) begin
			// Only implemented bits are stored, so reserved bits stay zero.
			if (idx == `SQFLM_IDX_SEQ_CTRL)
				ctrl_q <= pwdata[1:0];
			if (idx == `SQFLM_IDX_THRESH) begin
				thr_q <= pwdata[`SQFLM_THR_MSB:`SQFLM_THR_LSB];
				hys_q <= pwdata[`SQFLM_HYS_MSB:`SQFLM_HYS_LSB];
			end
			if (idx == `SQFLM_IDX_IRQ_MASK)
				mask_q <= pwdata[1:0];
		end
	end

	// ****************************************
	// Field-loss comparison
	// ****************************************
	// Widened so threshold times 64 plus hysteresis never wraps.
	wire [MAG_W+15:0] lim = {{(MAG_W+2){1'b0}}, thr_q, 6'h00};
	wire [MAG_W+15:0] hyst_amt = lim >> hys_q;
	wire [MAG_W+15:0] upper = lim + hyst_amt;
	wire [MAG_W+15:0] mag_w = {16'h0000, magnitude};
	// Comparison is only made on a fresh sample so a halted sequencer freezes the flag.
	wire smp = magnitude_valid & seq_run;
	wire go_lost = smp & ~lost_q & (mag_w < lim);
	wire go_ok = smp & lost_q & (mag_w > upper);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lost_q <= 1'b0;
		else if (go_lost)
			lost_q <= 1'b1;
		else if (go_ok)
			lost_q <= 1'b0;
	end

	// Sticky events: a new event beats a write-one-to-clear in the same cycle.
	wire [1:0] ev = {go_ok, go_lost};
	wire [1:0] clr = (wr && idx == `SQFLM_IDX_IRQ_STAT) ? pwdata[1:0] : 2'h0;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stat_q <= 2'h0;
		else
			stat_q <= (stat_q & ~clr) | ev;
	end

	// ****************************************
	// Read data
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel & ~penable & ~pwrite) begin
			case (idx)
				`SQFLM_IDX_SEQ_CTRL: prdata <= {30'h00000000, ctrl_q};
				`SQFLM_IDX_THRESH: prdata <= {21'h000000, hys_q, thr_q};
				`SQFLM_IDX_IRQ_STAT: prdata <= {30'h00000000, stat_q};
				`SQFLM_IDX_IRQ_MASK: prdata <= {30'h00000000, mask_q};
				`SQFLM_IDX_FLAG: prdata <= {31'h00000000, lost_q};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

endmodule // sqflm_top

/* File: sim/sqflm_properties.sv */
// Port checker for sqflm_top, bound below.
// Assumes the zero-wait APB slave and the one-cycle magnitude strobe.
module sqflm_properties (
	input logic pclk, presetn, psel, penable, pwrite, magnitude_valid, pslverr,
	input logic [15:0] magnitude,
	input logic seq_run, single_loop_select, field_lost_flag,
	input logic [13:0] paddr,
	input logic [31:0] pwdata, prdata
);
	timeunit 1ns;
	timeprecision 1ns;
	wire ctl = psel && penable && paddr == 14'h38;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ctrl_reset: assert property ($rose(presetn) |-> seq_run && !single_loop_select)
		else $error("reset");
	a_ctrl_write: assert property (ctl && pwrite |=>
		{seq_run, single_loop_select} == $past(pwdata[1:0])) else $error("write");
	a_ctrl_read: assert property (ctl && !pwrite |->
		prdata == {30'h0, seq_run, single_loop_select}) else $error("read");
	a_flag_idle: assert property (!(magnitude_valid && seq_run) |=>
		$stable(field_lost_flag)) else $error("flag");
	a_flag_high_clear: assert property (magnitude_valid && seq_run && magnitude == 16'hFFFF |=>
		!field_lost_flag) else $error("clear");
	a_slverr_unmapped: assert property (psel && penable && paddr[13:2] > 12'h012 |->
		pslverr) else $error("slverr");
endmodule // sqflm_properties
bind sqflm_top sqflm_properties chk_u (.*);

/* File: sim/tb.sv */
// Bench for sqflm_top: APB and magnitude are driven here.
// Assumes the bound port checker.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, magnitude_valid = 1'h0;
	logic [13:0] paddr = 14'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [15:0] magnitude = 16'h0;
	logic pready, pslverr, seq_run, single_loop_select, field_lost_flag, irq, es;
	int err_total = 0, n_tests = 0, cyc = 0;
	logic [16:0] rows [4] = '{17'h000C8, 17'h100BF, 17'h10120, 17'h00121};
	sqflm_top dut_u (.*);
	initial forever #5 pclk = ~pclk;
	always @(posedge pclk) if (++cyc > 2000) complete_run(1);
	task automatic chk(input string n, input logic [31:0] e, s);
		n_tests++;
		if (s !== e) $display("[FAIL] %s exp %h got %h", n, e, s);
		err_total += int'(s !== e);
	endtask
	// Waits on pready instead of trusting the zero-wait answer.
	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		@(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
		@(posedge pclk) penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		es = pslverr;
		{psel, penable} <= 2'h0;
		@(posedge pclk);
	endtask
	task automatic mag(input logic [15:0] m, input logic e);
		@(posedge pclk) {magnitude, magnitude_valid} <= {m, 1'h1};
		@(posedge pclk) magnitude_valid <= 1'h0;
		@(posedge pclk) chk("flag", 32'(e), 32'(field_lost_flag));
	endtask
	task automatic complete_run(input int late);
		err_total += late;
		$display("%0d checks %0d errors", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		foreach (rows[i]) mag(rows[i][15:0], rows[i][16]);
		$display("table done");
		apb(1'h0, 14'h38, 32'h0);
		chk("control", 32'h2, r);
		chk("slverr", 32'h0, 32'(es));
		apb(1'h0, 14'h40, 32'h0);
		chk("status", 32'h3, r);
		apb(1'h0, 14'h3C, 32'h0);
		chk("monitor", 32'h103, r);
		apb(1'h1, 14'h38, 32'hFFFFFFFD);
		mag(16'h00BF, 1'h0);
		apb(1'h0, 14'h38, 32'h0);
		chk("control", 32'h1, r);
		apb(1'h1, 14'h38, 32'h2);
		apb(1'h1, 14'h3C, 32'h705);
		mag(16'h013F, 1'h1);
		mag(16'h0142, 1'h1);
		apb(1'h0, 14'h48, 32'h0);
		chk("flag read", 32'h1, r);
		mag(16'hFFFF, 1'h0);
		mag(16'h0143, 1'h0);
		chk("irq", 32'h0, 32'(irq));
		apb(1'h1, 14'h44, 32'h1);
		chk("irq", 32'h1, 32'(irq));
		apb(1'h0, 14'h44, 32'h0);
		chk("mask", 32'h1, r);
		apb(1'h1, 14'h40, 32'h3);
		chk("irq", 32'h0, 32'(irq));
		apb(1'h0, 14'h100, 32'h0);
		chk("unmapped", 32'h0, r);
		chk("slverr", 32'h1, 32'(es));
		$display("hand tests done");
		apb(1'h1, 14'h38, 32'h1);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, 14'h38, 32'h0);
		chk("control reset", 32'h2, r);
		apb(1'h0, 14'h3C, 32'h0);
		chk("monitor reset", 32'h103, r);
		$display("reset tests done");
		complete_run(0);
	end
endmodule // tb
